//--- rtl/lcs_pkg.sv
// constants for the link control and self-identity register block
package lcs_pkg;
  // register byte offsets
  localparam logic [11:0] LCS_OFF_CTRL_SET = 12'h050;
  localparam logic [11:0] LCS_OFF_CTRL_CLR = 12'h054;
  localparam logic [11:0] LCS_OFF_BUF_BASE = 12'h064;
  localparam logic [11:0] LCS_OFF_COUNT = 12'h068;
  localparam logic [11:0] LCS_OFF_MISC = 12'h200;
  // phy-clocked windows, inclusive
  localparam logic [11:0] LCS_PHY_LO_A = 12'h0dc;
  localparam logic [11:0] LCS_PHY_HI_A = 12'h0f0;
  localparam logic [11:0] LCS_PHY_LO_B = 12'h100;
  localparam logic [11:0] LCS_PHY_HI_B = 12'h11c;
  // control field positions
  localparam int LCS_BIT_PWR = 19;
  localparam int LCS_BIT_PWA = 18;
  localparam int LCS_BIT_LAE = 17;
  localparam int LCS_BIT_SRT = 16;
  // miscellaneous configuration field
  localparam int LCS_BIT_STA = 4;
  // buffer base writable bits
  localparam logic [31:0] LCS_BASE_MASK = 32'hfffff800;
  localparam int LCS_BASE_LO = 11;
  // count register fields
  localparam int LCS_BIT_ERR = 31;
  localparam int LCS_GEN_HI = 23;
  localparam int LCS_GEN_LO = 16;
  localparam int LCS_QUAD_HI = 10;
  localparam int LCS_QUAD_LO = 2;
  // reset values
  localparam logic [31:0] LCS_RST_BASE = 32'h00000000;
  localparam logic [7:0] LCS_RST_GEN = 8'h00;
  // soft reset length in clock cycles
  localparam logic [3:0] LCS_SOFT_RESET_CYCLES = 4'h8;
  // axi responses
  localparam logic [1:0] LCS_RESP_OKAY = 2'b00;
  localparam logic [1:0] LCS_RESP_SLVERR = 2'b10;
  localparam logic [1:0] LCS_RESP_DECERR = 2'b11;
  localparam logic [31:0] LCS_ALL_ONES = 32'hffffffff;
endpackage : lcs_pkg

//--- rtl/lcs_sync2.sv
// two-flop synchroniser for one level from outside the clock domain
`timescale 1ns/10ps
module lcs_sync2 (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // level in and out
  input wire logic i_async,
  output logic o_sync
);
  logic meta_reg; // first stage, read only by the second

  // plain two-stage chain, no logic between stages
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      meta_reg <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule : lcs_sync2

//--- rtl/lcs_soft_reset.sv
// software reset sequencer: holds busy for a fixed number of cycles
`timescale 1ns/10ps
module lcs_soft_reset (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // request and state
  input wire logic i_start,
  output logic o_busy
);
  logic [3:0] cnt_reg; // cycles still to run

  // busy stays up until the count runs out; a start while busy is ignored
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      cnt_reg <= 4'h0;
      o_busy <= 1'b0;
    end else if (i_start && !o_busy) begin
      cnt_reg <= lcs_pkg::LCS_SOFT_RESET_CYCLES - 4'h1;
      o_busy <= 1'b1;
    end else if (o_busy) begin
      if (cnt_reg == 4'h0) begin
        o_busy <= 1'b0; // self-clears when done
      end else begin
        cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end

  property p_busy_len;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_start && !o_busy) |=> o_busy [*8] ##1 !o_busy;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("soft reset length wrong");
endmodule : lcs_soft_reset

//--- rtl/lcs_link_regs.sv
// link control and self-identity registers behind an axi4-lite slave
`timescale 1ns/10ps
module lcs_link_regs (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // axi4-lite write address
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [11:0] i_s_axi_awaddr,
  // axi4-lite write data
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  // axi4-lite write response
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  output logic [1:0] o_s_axi_bresp,
  // axi4-lite read address
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  input wire logic [11:0] i_s_axi_araddr,
  // axi4-lite read data
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  // phy clock status pin
  input wire logic i_phy_clk_running,
  // link core events, same clock
  input wire logic i_bus_reset,
  input wire logic i_rx_start,
  input wire logic i_rx_valid,
  output logic o_rx_ready,
  input wire logic [31:0] i_rx_data,
  input wire logic i_rx_done,
  input wire logic i_rx_hw_error,
  // self-identity buffer writes to host memory
  output logic o_dma_valid,
  input wire logic i_dma_ready,
  output logic [31:0] o_dma_addr,
  output logic [31:0] o_dma_data,
  input wire logic i_dma_error,
  // link controls
  output logic o_phy_link_allow,
  output logic o_posted_write_allow,
  output logic o_link_connected,
  output logic o_link_state_reset
);
  // synchronised phy clock status
  logic phy_run;
  // soft reset in progress
  logic sr_busy;
  // control and configuration flops
  logic pwr_reg, pwa_reg, lae_reg, sta_reg;
  logic [31:0] base_reg;
  // count register fields
  logic err_reg, err_pend_reg;
  logic [7:0] gen_reg;
  logic [8:0] quad_reg;
  // axi write side holding flops
  logic aw_held_reg, w_held_reg;
  logic [11:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  // axi read side
  logic [11:0] rd_addr_reg; // kept for checking only
  // decoded write
  logic wr_fire;
  logic [1:0] wr_resp;
  logic [31:0] wmask;
  logic set_hit, clr_hit, base_hit, misc_hit, sr_start;
  // register images
  logic [31:0] ctrl_img, count_img;
  // read decode
  logic [1:0] rd_resp;
  logic [31:0] rd_data;
  // gated link events
  logic rx_take, dma_take, bus_reset_seen;

  lcs_sync2 u_phy_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_async(i_phy_clk_running),
    .o_sync(phy_run)
  );

  lcs_soft_reset u_soft_reset (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_start(sr_start),
    .o_busy(sr_busy)
  );

  // response for an address: own registers, phy window, or unmapped
  function automatic logic [1:0] decode_resp(input logic [11:0] a, input logic run,
                                             input logic sta);
    logic phy_win;
    phy_win = ((a >= lcs_pkg::LCS_PHY_LO_A) && (a <= lcs_pkg::LCS_PHY_HI_A)) ||
              ((a >= lcs_pkg::LCS_PHY_LO_B) && (a <= lcs_pkg::LCS_PHY_HI_B));
    if (a[1:0] != 2'b00) begin
      decode_resp = lcs_pkg::LCS_RESP_DECERR;
    end else if (a == lcs_pkg::LCS_OFF_CTRL_SET || a == lcs_pkg::LCS_OFF_CTRL_CLR ||
                 a == lcs_pkg::LCS_OFF_BUF_BASE || a == lcs_pkg::LCS_OFF_COUNT ||
                 a == lcs_pkg::LCS_OFF_MISC) begin
      decode_resp = lcs_pkg::LCS_RESP_OKAY;
    end else if (phy_win && !run && !sta) begin
      decode_resp = lcs_pkg::LCS_RESP_SLVERR; // target abort
    end else if (phy_win && !run) begin
      decode_resp = lcs_pkg::LCS_RESP_OKAY; // answered with all ones
    end else begin
      decode_resp = lcs_pkg::LCS_RESP_DECERR; // phy registers live elsewhere
    end
  endfunction : decode_resp

  // images with reserved bits as zero
  always_comb begin
    ctrl_img = 32'h00000000; // bits 21:20 and 15:0 stay zero
    ctrl_img[lcs_pkg::LCS_BIT_PWR] = pwr_reg;
    ctrl_img[lcs_pkg::LCS_BIT_PWA] = pwa_reg;
    ctrl_img[lcs_pkg::LCS_BIT_LAE] = lae_reg;
    ctrl_img[lcs_pkg::LCS_BIT_SRT] = sr_busy; // one while reset runs
    count_img = 32'h00000000; // reserved fields zero
    count_img[lcs_pkg::LCS_BIT_ERR] = err_reg;
    count_img[lcs_pkg::LCS_GEN_HI:lcs_pkg::LCS_GEN_LO] = gen_reg;
    count_img[lcs_pkg::LCS_QUAD_HI:lcs_pkg::LCS_QUAD_LO] = quad_reg;
  end

  // write channel handshakes; each channel is held until both are in
  assign o_s_axi_awready = !aw_held_reg;
  assign o_s_axi_wready = !w_held_reg;
  assign wr_fire = aw_held_reg && w_held_reg && !o_s_axi_bvalid;
  assign wr_resp = decode_resp(aw_addr_reg, phy_run, sta_reg);

  // byte lanes widened to a bit mask
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign wmask[gi*8 +: 8] = {8{w_strb_reg[gi]}};
    end
  endgenerate

  // write hits; control and base writes while soft reset runs are dropped
  assign set_hit = wr_fire && !sr_busy && (aw_addr_reg == lcs_pkg::LCS_OFF_CTRL_SET);
  assign clr_hit = wr_fire && !sr_busy && (aw_addr_reg == lcs_pkg::LCS_OFF_CTRL_CLR);
  assign base_hit = wr_fire && !sr_busy && (aw_addr_reg == lcs_pkg::LCS_OFF_BUF_BASE);
  assign misc_hit = wr_fire && (aw_addr_reg == lcs_pkg::LCS_OFF_MISC);
  assign sr_start = set_hit && w_data_reg[lcs_pkg::LCS_BIT_SRT] &&
                    wmask[lcs_pkg::LCS_BIT_SRT];

  // address and data capture, in either order
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= i_s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= i_s_axi_wdata;
        w_strb_reg <= i_s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // write response one cycle after both halves are in
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= lcs_pkg::LCS_RESP_OKAY;
    end else if (wr_fire) begin
      o_s_axi_bvalid <= 1'b1;
      o_s_axi_bresp <= wr_resp;
    end else if (i_s_axi_bready) begin
      o_s_axi_bvalid <= 1'b0;
    end
  end

  // read data mux
  always_comb begin
    rd_resp = decode_resp(i_s_axi_araddr, phy_run, sta_reg);
    case (i_s_axi_araddr)
      lcs_pkg::LCS_OFF_CTRL_SET: rd_data = ctrl_img; // both views read the same
      lcs_pkg::LCS_OFF_CTRL_CLR: rd_data = ctrl_img;
      lcs_pkg::LCS_OFF_BUF_BASE: rd_data = base_reg & lcs_pkg::LCS_BASE_MASK;
      lcs_pkg::LCS_OFF_COUNT: rd_data = count_img;
      lcs_pkg::LCS_OFF_MISC: begin
        rd_data = 32'h00000000;
        rd_data[lcs_pkg::LCS_BIT_STA] = sta_reg;
      end
      default: begin
        // stopped phy clock with abort suppressed answers all ones
        rd_data = (rd_resp == lcs_pkg::LCS_RESP_OKAY) ? lcs_pkg::LCS_ALL_ONES : 32'h00000000;
      end
    endcase
  end

  // read channel: one read at a time, answered the cycle after address
  assign o_s_axi_arready = !o_s_axi_rvalid;
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h00000000;
      o_s_axi_rresp <= lcs_pkg::LCS_RESP_OKAY;
      rd_addr_reg <= 12'h000;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rdata <= rd_data;
      o_s_axi_rresp <= rd_resp;
      rd_addr_reg <= i_s_axi_araddr;
    end else if (i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
    end
  end

  // control bits: set view sets, clear view clears, any reset clears all
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || sr_busy) begin
      pwr_reg <= 1'b0;
      pwa_reg <= 1'b0;
      lae_reg <= 1'b0; // hardware or soft reset
    end else if (sr_start) begin
      lae_reg <= 1'b0; // reset takes priority over bits written with it
      pwr_reg <= 1'b0;
      pwa_reg <= 1'b0;
    end else if (set_hit) begin
      pwr_reg <= pwr_reg | (w_data_reg[lcs_pkg::LCS_BIT_PWR] & wmask[lcs_pkg::LCS_BIT_PWR]);
      pwa_reg <= pwa_reg | (w_data_reg[lcs_pkg::LCS_BIT_PWA] & wmask[lcs_pkg::LCS_BIT_PWA]);
      lae_reg <= lae_reg | (w_data_reg[lcs_pkg::LCS_BIT_LAE] & wmask[lcs_pkg::LCS_BIT_LAE]);
    end else if (clr_hit) begin
      pwr_reg <= pwr_reg & ~(w_data_reg[lcs_pkg::LCS_BIT_PWR] & wmask[lcs_pkg::LCS_BIT_PWR]);
      pwa_reg <= pwa_reg & ~(w_data_reg[lcs_pkg::LCS_BIT_PWA] & wmask[lcs_pkg::LCS_BIT_PWA]);
      lae_reg <= lae_reg & ~(w_data_reg[lcs_pkg::LCS_BIT_LAE] & wmask[lcs_pkg::LCS_BIT_LAE]);
    end
  end

  // abort suppression is configuration space; soft reset leaves it alone
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      sta_reg <= 1'b0;
    end else if (misc_hit && wmask[lcs_pkg::LCS_BIT_STA]) begin
      sta_reg <= w_data_reg[lcs_pkg::LCS_BIT_STA];
    end
  end

  // buffer base, low eleven bits never stored
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || sr_busy) begin
      base_reg <= lcs_pkg::LCS_RST_BASE;
    end else if (base_hit) begin
      base_reg <= ((base_reg & ~wmask) | (w_data_reg & wmask)) & lcs_pkg::LCS_BASE_MASK;
    end
  end

  // link outputs follow the control bits directly
  assign o_phy_link_allow = pwr_reg;
  assign o_posted_write_allow = pwa_reg;
  assign o_link_connected = lae_reg && pwr_reg;
  assign o_link_state_reset = sr_busy; // flushes link state and fifos

  // reception is taken only while connected and the store stage is free
  assign o_rx_ready = o_link_connected && !o_dma_valid && !sr_busy;
  assign rx_take = i_rx_valid && o_rx_ready;
  assign dma_take = o_dma_valid && i_dma_ready;
  assign bus_reset_seen = i_bus_reset && o_link_connected;

  // one-entry store stage: quadlet n goes to base plus four times n
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || sr_busy) begin
      o_dma_valid <= 1'b0;
      o_dma_addr <= 32'h00000000;
      o_dma_data <= 32'h00000000;
    end else if (rx_take) begin
      o_dma_valid <= 1'b1;
      o_dma_addr <= {base_reg[31:lcs_pkg::LCS_BASE_LO], quad_reg, 2'b00};
      o_dma_data <= i_rx_data;
    end else if (dma_take) begin
      o_dma_valid <= 1'b0;
    end
  end

  // quadlet count: cleared at start, one per quadlet stored
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || sr_busy) begin
      quad_reg <= 9'h000;
    end else if (i_rx_start) begin
      quad_reg <= 9'h000;
    end else if (dma_take) begin
      quad_reg <= quad_reg + 9'h001; // header quadlet included
    end
  end

  // generation: counts bus resets seen while connected, wraps by natural overflow
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || sr_busy) begin
      gen_reg <= lcs_pkg::LCS_RST_GEN;
    end else if (bus_reset_seen) begin
      gen_reg <= gen_reg + 8'h01;
    end
  end

  // error flag: host write errors gather during reception, decided at done
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || sr_busy) begin
      err_pend_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      if (i_dma_error) begin
        err_pend_reg <= 1'b1; // an error in the start cycle is kept
      end else if (i_rx_start) begin
        err_pend_reg <= 1'b0;
      end
      if (i_rx_done) begin
        // buffer must be treated as garbage while this is set
        err_reg <= err_pend_reg || i_rx_hw_error || i_dma_error;
      end
    end
  end

  property p_ctrl_rsvd;
    @(posedge i_clk) disable iff (!i_reset_n)
      (o_s_axi_rvalid && rd_addr_reg == lcs_pkg::LCS_OFF_CTRL_SET) |->
        (o_s_axi_rdata[21:20] == 2'b00);
  endproperty
  a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("ctrl bits 21:20 not zero");

  property p_ctrl_low;
    @(posedge i_clk) disable iff (!i_reset_n)
      (o_s_axi_rvalid && rd_addr_reg == lcs_pkg::LCS_OFF_CTRL_CLR) |->
        (o_s_axi_rdata[15:0] == 16'h0000);
  endproperty
  a_ctrl_low: assert property (p_ctrl_low) else $error("ctrl bits 15:0 not zero");

  property p_pwr_gate;
    @(posedge i_clk) disable iff (!i_reset_n)
      (set_hit && !sr_start && w_data_reg[19] && w_strb_reg[2]) |=> o_phy_link_allow;
  endproperty
  a_pwr_gate: assert property (p_pwr_gate) else $error("link-phy not allowed after set");

  property p_abort;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_s_axi_arvalid && o_s_axi_arready && i_s_axi_araddr == lcs_pkg::LCS_PHY_LO_B &&
       !phy_run && !sta_reg) |=> (o_s_axi_rvalid && o_s_axi_rresp == lcs_pkg::LCS_RESP_SLVERR);
  endproperty
  a_abort: assert property (p_abort) else $error("no target abort on stopped phy clock");

  property p_all_ones;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_s_axi_arvalid && o_s_axi_arready && i_s_axi_araddr == lcs_pkg::LCS_PHY_HI_A &&
       !phy_run && sta_reg) |=> (o_s_axi_rdata == 32'hffffffff && o_s_axi_rresp == 2'b00);
  endproperty
  a_all_ones: assert property (p_all_ones) else $error("suppressed abort not all ones");

  property p_lae_reset;
    @(posedge i_clk) disable iff (!i_reset_n)
      sr_start |=> (!lae_reg && sr_busy) ##1 !o_link_connected;
  endproperty
  a_lae_reset: assert property (p_lae_reset) else $error("link enable survived reset");

  property p_disconnect;
    @(posedge i_clk) disable iff (!i_reset_n)
      !lae_reg |-> (!o_rx_ready && !bus_reset_seen);
  endproperty
  a_disconnect: assert property (p_disconnect) else $error("traffic while link disabled");

  property p_gen_inc;
    @(posedge i_clk) disable iff (!i_reset_n)
      (bus_reset_seen && !sr_busy) |=> (gen_reg == 8'($past(gen_reg) + 8'h01));
  endproperty
  a_gen_inc: assert property (p_gen_inc) else $error("generation did not advance");

  property p_quad_clear;
    @(posedge i_clk) disable iff (!i_reset_n)
      i_rx_start |=> (count_img[10:2] == 9'h000);
  endproperty
  a_quad_clear: assert property (p_quad_clear) else $error("quadlet count not cleared");

  property p_err_set;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_rx_done && i_rx_hw_error && !sr_busy) |=> count_img[31];
  endproperty
  a_err_set: assert property (p_err_set) else $error("error flag not set");

  property p_base_low;
    @(posedge i_clk) disable iff (!i_reset_n)
      (o_s_axi_rvalid && rd_addr_reg == lcs_pkg::LCS_OFF_BUF_BASE) |->
        (o_s_axi_rdata[10:0] == 11'h000);
  endproperty
  a_base_low: assert property (p_base_low) else $error("buffer base low bits not zero");
endmodule : lcs_link_regs

//--- test/lcs_host_mem_model.sv
// host memory model answering self-identity buffer writes
`timescale 1ns/10ps
module lcs_host_mem_model (
  // clock
  input wire logic i_clk,
  // buffer write port
  input wire logic i_valid,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_data,
  output logic o_ready,
  output logic o_error,
  // behaviour set by the bench
  input wire logic [1:0] i_wait,
  input wire logic i_fail
);
  logic [31:0] mem [logic [31:0]]; // sparse host memory
  logic [1:0] wait_reg; // idle cycles spent on the pending word
  initial begin
    o_ready = 1'b0;
    o_error = 1'b0;
    wait_reg = 2'h0;
  end
  // take a word after i_wait plus one idle cycles; a failing host bus flags once per word
  always @(posedge i_clk) begin
    o_error <= 1'b0;
    if (i_valid && o_ready) begin
      mem[i_addr] = i_data;
      o_error <= i_fail;
      o_ready <= 1'b0;
      wait_reg <= 2'h0;
    end else if (i_valid) begin
      o_ready <= (wait_reg >= i_wait);
      wait_reg <= wait_reg + 2'h1;
    end else begin
      o_ready <= 1'b0;
    end
  end
endmodule : lcs_host_mem_model

//--- test/link_control_selfid_regs_tb_top.sv
// self-checking bench for the link control and self-identity registers
`timescale 1ns/10ps
module link_control_selfid_regs_tb_top;
  logic i_clk = 1'b0, i_reset_n = 1'b0;
  logic awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h0, rxd = 32'h0, rd;
  logic phy = 1'b0, br = 1'b0, rxs = 1'b0, rxv = 1'b0, rxe = 1'b0, hwe = 1'b0, fl = 1'b0;
  logic [1:0] dly = 2'h0, bresp, rresp;
  logic [3:0] ws = 4'hf; // write byte strobes
  logic awr, wr, bv, arr, rv, rxr, dv, dr, de, pla, pwa, con, lsr;
  logic [31:0] rdat, da, dd;
  int fails = 0, compares = 0;
  always #50 i_clk = ~i_clk;
  lcs_link_regs dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_s_axi_awvalid(awv),
    .o_s_axi_awready(awr), .i_s_axi_awaddr(awa), .i_s_axi_wvalid(wv), .o_s_axi_wready(wr),
    .i_s_axi_wdata(wd), .i_s_axi_wstrb(ws), .o_s_axi_bvalid(bv), .i_s_axi_bready(brd),
    .o_s_axi_bresp(bresp), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
    .i_s_axi_araddr(ara), .o_s_axi_rvalid(rv), .i_s_axi_rready(rrd), .o_s_axi_rdata(rdat),
    .o_s_axi_rresp(rresp), .i_phy_clk_running(phy), .i_bus_reset(br), .i_rx_start(rxs),
    .i_rx_valid(rxv), .o_rx_ready(rxr), .i_rx_data(rxd), .i_rx_done(rxe),
    .i_rx_hw_error(hwe), .o_dma_valid(dv), .i_dma_ready(dr), .o_dma_addr(da),
    .o_dma_data(dd), .i_dma_error(de), .o_phy_link_allow(pla),
    .o_posted_write_allow(pwa), .o_link_connected(con), .o_link_state_reset(lsr));
  lcs_host_mem_model pm (.i_clk(i_clk), .i_valid(dv), .i_addr(da), .i_data(dd),
    .o_ready(dr), .o_error(de), .i_wait(dly), .i_fail(fl));
  // one comparison, counted; mismatches reported at once
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask : chk
  // axi4-lite write; both halves offered together, each dropped when taken
  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    logic ad, dn;
    ad = 1'b0;
    dn = 1'b0;
    @(posedge i_clk);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; brd <= 1'b1;
    while (!(ad && dn)) begin
      @(posedge i_clk);
      if (awv && awr) begin ad = 1'b1; awv <= 1'b0; end
      if (wv && wr) begin dn = 1'b1; wv <= 1'b0; end
    end
    do @(posedge i_clk); while (!bv);
    chk("bresp", {30'h0, lcs_pkg::LCS_RESP_OKAY}, {30'h0, bresp});
    brd <= 1'b0;
  endtask : axw
  // axi4-lite read, then data and response compared
  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e,
                     input logic [1:0] r);
    @(posedge i_clk);
    ara <= a; arv <= 1'b1; rrd <= 1'b1;
    do @(posedge i_clk); while (!arr);
    arv <= 1'b0;
    do @(posedge i_clk); while (!rv);
    rrd <= 1'b0;
    chk(n, e, rdat);
    chk({n, " resp"}, {30'h0, r}, {30'h0, rresp});
  endtask : rdc
  // one detected bus reset
  task automatic busrst();
    @(posedge i_clk);
    br <= 1'b1;
    @(posedge i_clk);
    br <= 1'b0;
  endtask : busrst
  // one self-identity reception of n quadlets; valid held across quadlets
  task automatic sid(input int n, input logic h);
    @(posedge i_clk);
    rxs <= 1'b1;
    @(posedge i_clk);
    rxs <= 1'b0;
    for (int i = 0; i < n; i++) begin
      rxv <= 1'b1;
      rxd <= {24'h5a0000, i[7:0]};
      do @(posedge i_clk); while (!rxr);
    end
    rxv <= 1'b0;
    repeat (2) @(posedge i_clk);
    while (dv) @(posedge i_clk);
    @(posedge i_clk); // let a late host bus error land before done
    rxe <= 1'b1; hwe <= h;
    @(posedge i_clk);
    rxe <= 1'b0; hwe <= 1'b0;
  endtask : sid
  task automatic stop_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  // receptions: quadlets, host bus fault, hardware fault
  int nq[4] = '{3, 2, 1, 4};
  logic [3:0] bf = 4'b0010, hf = 4'b0100;
  initial begin
    repeat (20) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rdc("ctrl", 12'h050, 32'h0, 2'b00);
    rdc("base", 12'h064, lcs_pkg::LCS_RST_BASE, 2'b00);
    busrst();
    rdc("count", 12'h068, 32'h0, 2'b00);
    chk("rx_ready", 32'h0, {31'h0, rxr});
    $display("test reset values done");
    axw(12'h050, 32'h00040000);
    rdc("ctrl", 12'h054, 32'h00040000, 2'b00);
    axw(12'h054, 32'h00040000);
    chk("pwa", 32'h0, {31'h0, pwa});
    axw(12'h050, 32'h00040000);
    axw(12'h050, 32'hfffaffff);
    repeat (20) @(posedge i_clk); // short stand-in for the power settle wait
    rdc("ctrl", 12'h050, 32'h000e0000, 2'b00);
    chk("outs", 32'h7, {29'h0, pla, pwa, con});
    $display("test control done");
    axw(12'h064, 32'hffffffff);
    rdc("base", 12'h064, lcs_pkg::LCS_BASE_MASK, 2'b00);
    ws <= 4'h4;
    axw(12'h064, 32'h00000000);
    ws <= 4'hf;
    rdc("base", 12'h064, 32'hff00f800, 2'b00);
    axw(12'h064, 32'h000128ff);
    rdc("base", 12'h064, 32'h00012800, 2'b00);
    rdc("phy", 12'h0dc, 32'h0, lcs_pkg::LCS_RESP_SLVERR);
    rdc("phy", 12'h100, 32'h0, lcs_pkg::LCS_RESP_SLVERR);
    axw(12'h200, 32'h00000010);
    rdc("phy", 12'h0f0, lcs_pkg::LCS_ALL_ONES, 2'b00);
    phy <= 1'b1;
    repeat (4) @(posedge i_clk);
    rdc("phy", 12'h100, 32'h0, lcs_pkg::LCS_RESP_DECERR);
    rdc("hole", 12'h004, 32'h0, lcs_pkg::LCS_RESP_DECERR);
    $display("test map done");
    repeat (257) busrst();
    rdc("count", 12'h068, 32'h00010000, 2'b00);
    $display("test generation done");
    for (int k = 0; k < 4; k++) begin
      fl <= bf[k];
      dly <= 2'(k);
      sid(nq[k], hf[k]);
      rdc("count", 12'h068, {bf[k] | hf[k], 15'h0001, 5'h0, 9'(nq[k]), 2'h0}, 2'b00);
      for (int i = 0; i < nq[k] && !(bf[k] | hf[k]); i++)
        chk("mem", {24'h5a0000, 8'(i)}, pm.mem[32'h00012800 + 4 * i]);
    end
    fl <= 1'b0;
    $display("test reception done");
    axw(12'h050, 32'h00010000);
    rdc("ctrl", 12'h050, 32'h00010000, 2'b00);
    chk("lsr", 32'h1, {31'h0, lsr});
    repeat (10) @(posedge i_clk);
    rdc("ctrl", 12'h050, 32'h0, 2'b00);
    rdc("base", 12'h064, 32'h0, 2'b00);
    rdc("count", 12'h068, 32'h0, 2'b00);
    rdc("misc", 12'h200, 32'h00000010, 2'b00);
    chk("con", 32'h0, {31'h0, con});
    $display("test soft reset done");
    stop_test();
  end
  // watchdog well beyond the expected eight hundred or so cycles
  initial begin
    repeat (6000) @(posedge i_clk);
    fails++;
    stop_test();
  end
endmodule : link_control_selfid_regs_tb_top
